//--- rtl/opc_output_path_ctrl.sv
// Purpose: output path enable control with sequencing and clock check
// Assumes: register port on the core clock, read data one cycle later
// Notes: three channels, headphone left/right and speaker left
//
// Function
// [RULE1] Exactly three channels exist: headphone left, headphone right and speaker left.
// [RULE2] The enable register holds speaker left at bit 7, headphone left at 1, right at 0, all reset to 0.
// [RULE3] A channel drives no output unless its enable bit was set.
// [RULE4] Channels start muted and software unmutes last on enable and mutes first on disable.
// [RULE5] The headphone charge pump is switched on by hardware whenever the headphone drivers need it.
// [RULE6] Setting or clearing an enable bit runs a pop-suppressed sequence for that path.
// [RULE7] Completion of a headphone sequence is an interrupt source.
// [RULE8] The headphone sequence state can be shown on the general-purpose pin.
// [RULE9] Software sets up the core clock before enabling any path.
// [RULE10] An enable is refused and the path stays off when core clock cycles are too few.
// [RULE11] A refused enable leaves paths already active untouched.
// [RULE12] An underclock error is reported to the interrupt logic and the general-purpose pin.
// [RULE13] Status shows enabled paths: speaker left at bit 7 of status, headphones at bits 1 and 0 of raw status.
// [RULE14] Headphones run stereo single-ended by default, or as one bridge-tied mono output.
// [RULE15] The speaker channel is phase inverted against the headphones.
// [RULE16] All channels run at one sample rate set by the rate field.
// [RULE17] A status bit changes only when its sequence ends and stays clear after a refused enable.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module opc_output_path_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [9:0] clk_cycles_avail_i,
    output logic [15:0] reg_rdata_o,
    output opc_pkg::opc_paths_s path_drive_o,
    output logic charge_pump_en_o,
    output logic hp_mono_btl_o,
    output logic spk_phase_invert_o,
    output logic [3:0] dac_rate_o,
    output logic irq_o,
    output logic gpio_o
);
    logic [15:0] enables;
    logic [15:0] config_reg;
    logic [opc_pkg::IRQ_W-1:0] irq_mask;
    logic [opc_pkg::IRQ_W-1:0] irq_status;
    logic [opc_pkg::IRQ_W-1:0] irq_set;
    logic [opc_pkg::NUM_CH-1:0] granted;
    logic [opc_pkg::NUM_CH-1:0] next_granted;
    logic [opc_pkg::NUM_CH-1:0] path_on;
    logic [opc_pkg::NUM_CH-1:0] path_busy;
    logic [opc_pkg::NUM_CH-1:0] path_done;
    logic [opc_pkg::NUM_CH-1:0] wr_bits;
    logic [opc_pkg::NUM_CH-1:0] new_req;
    logic [opc_pkg::NUM_CH-1:0] keep_req;
    logic [11:0] need_cycles;
    logic wr_enables;
    logic reject;
    logic underclk_evt;
    logic irq_clear_wr;
    logic hp_busy;
    logic [1:0] gpio_sel;

    // ----------------------------------------
    // clock budget of a set of paths
    // ----------------------------------------
    function automatic logic [11:0] path_cost(input logic [opc_pkg::NUM_CH-1:0] p);
        logic [11:0] sum;
        sum = 12'h000;
        if (p[opc_pkg::CH_SPK]) begin
            sum = sum + {2'h0, opc_pkg::SPK_PATH_CYCLES};
        end
        if (p[opc_pkg::CH_HPL]) begin
            sum = sum + {2'h0, opc_pkg::HP_PATH_CYCLES};
        end
        if (p[opc_pkg::CH_HPR]) begin
            sum = sum + {2'h0, opc_pkg::HP_PATH_CYCLES};
        end
        return sum;
    endfunction

    // ----------------------------------------
    // write decode and underclock check
    // ----------------------------------------
    assign wr_enables = reg_wr_i && (reg_addr_i == opc_pkg::ADDR_ENABLES);
    assign irq_clear_wr = reg_wr_i && (reg_addr_i == opc_pkg::ADDR_IRQ_STATUS);
    assign wr_bits = {reg_wdata_i[opc_pkg::BIT_SPEAKER_LEFT], reg_wdata_i[opc_pkg::BIT_HEADPHONE_LEFT],
                      reg_wdata_i[opc_pkg::BIT_HEADPHONE_RIGHT]};
    assign new_req = wr_bits & ~granted;
    assign keep_req = wr_bits & granted;
    assign need_cycles = path_cost(wr_bits);
    assign reject = wr_enables && (new_req != 3'h0) && (need_cycles > {2'h0, clk_cycles_avail_i}); // see [RULE10]
    assign underclk_evt = reject;
    assign next_granted = reject ? keep_req : wr_bits; // see [RULE11]
    assign hp_busy = path_busy[opc_pkg::CH_HPL] | path_busy[opc_pkg::CH_HPR];
    assign gpio_sel = config_reg[opc_pkg::CFG_GPIO_LSB +: 2];

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enables <= opc_pkg::RESET_ENABLES;
        end else if (wr_enables) begin
            enables <= 16'h0000;
            enables[opc_pkg::BIT_SPEAKER_LEFT] <= reg_wdata_i[opc_pkg::BIT_SPEAKER_LEFT]; // see [RULE2]
            enables[opc_pkg::BIT_HEADPHONE_LEFT] <= reg_wdata_i[opc_pkg::BIT_HEADPHONE_LEFT];
            enables[opc_pkg::BIT_HEADPHONE_RIGHT] <= reg_wdata_i[opc_pkg::BIT_HEADPHONE_RIGHT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            granted <= 3'h0;
        end else if (wr_enables) begin
            granted <= next_granted; // see [RULE10]
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_reg <= opc_pkg::RESET_CONFIG;
            irq_mask <= opc_pkg::RESET_IRQ_MASK;
        end else if (reg_wr_i) begin
            if (reg_addr_i == opc_pkg::ADDR_CONFIG) begin
                config_reg <= {8'h00, reg_wdata_i[7:0]};
            end
            if (reg_addr_i == opc_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= reg_wdata_i[opc_pkg::IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // one sequencer per channel
    // ----------------------------------------
    for (genvar ch = 0; ch < opc_pkg::NUM_CH; ch++) begin : g_path // see [RULE1]
        opc_path_seq u_seq (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .request_i(granted[ch]), // see [RULE6]
            .enabled_o(path_on[ch]), // see [RULE17]
            .busy_o(path_busy[ch]),
            .done_o(path_done[ch])
        );
    end

    // ----------------------------------------
    // interrupt flags
    // ----------------------------------------
    assign irq_set[opc_pkg::IRQ_HP_DONE] = path_done[opc_pkg::CH_HPL] | path_done[opc_pkg::CH_HPR]; // see [RULE7]
    assign irq_set[opc_pkg::IRQ_SPK_DONE] = path_done[opc_pkg::CH_SPK];
    assign irq_set[opc_pkg::IRQ_UNDERCLK] = underclk_evt; // see [RULE12]

    for (genvar b = 0; b < opc_pkg::IRQ_W; b++) begin : g_irq
        opc_sticky_bit u_flag (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .set_i(irq_set[b]),
            .clear_i(irq_clear_wr && reg_wdata_i[b]),
            .flag_o(irq_status[b])
        );
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // general-purpose pin indication
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpio_o <= 1'b0;
        end else begin
            unique case (gpio_sel)
                opc_pkg::GPIO_SEL_SEQ: gpio_o <= hp_busy; // see [RULE8]
                opc_pkg::GPIO_SEL_UNDERCLK: gpio_o <= irq_status[opc_pkg::IRQ_UNDERCLK]; // see [RULE12]
                opc_pkg::GPIO_SEL_BOTH: gpio_o <= hp_busy | irq_status[opc_pkg::IRQ_UNDERCLK];
                default: gpio_o <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // analogue side controls
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            path_drive_o <= '0;
            charge_pump_en_o <= 1'b0;
            hp_mono_btl_o <= 1'b0;
            spk_phase_invert_o <= 1'b0;
            dac_rate_o <= 4'h0;
        end else begin
            path_drive_o <= opc_pkg::opc_paths_s'(path_on | path_busy); // see [RULE3]
            charge_pump_en_o <= |(path_on[1:0] | path_busy[1:0] | granted[1:0]); // see [RULE5]
            hp_mono_btl_o <= config_reg[opc_pkg::CFG_MONO]; // see [RULE14]
            spk_phase_invert_o <= 1'b1; // see [RULE15]
            dac_rate_o <= config_reg[opc_pkg::CFG_RATE_LSB +: opc_pkg::RATE_W]; // see [RULE16]
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                opc_pkg::ADDR_ENABLES: reg_rdata_o <= enables;
                opc_pkg::ADDR_STATUS: reg_rdata_o <= {8'h00, path_on[opc_pkg::CH_SPK], 7'h00}; // see [RULE13]
                opc_pkg::ADDR_RAW_STATUS: reg_rdata_o <= {14'h0000, path_on[1:0]};
                opc_pkg::ADDR_IRQ_STATUS: reg_rdata_o <= {13'h0000, irq_status};
                opc_pkg::ADDR_IRQ_MASK: reg_rdata_o <= {13'h0000, irq_mask};
                opc_pkg::ADDR_CONFIG: reg_rdata_o <= config_reg;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    a_status_after_seq: assert property (((path_on ^ $past(path_on)) & ~$past(path_done)) == 3'h0) // see [RULE17]
        else $error("path status changed without a finished sequence");
    a_drive_needs_grant: assert property ((3'(path_drive_o) & ~$past(3'(path_drive_o)) & ~$past(granted, 3)) == 3'h0) // see [RULE3]
        else $error("path drive started without an enable");
    a_reject_keeps_active: assert property (underclk_evt |=> granted == $past(keep_req)) // see [RULE11]
        else $error("refused enable disturbed active paths");
    a_reject_no_status: assert property (underclk_evt && new_req[opc_pkg::CH_SPK] && !path_busy[opc_pkg::CH_SPK]
        && !path_on[opc_pkg::CH_SPK] |-> ##3 !path_busy[opc_pkg::CH_SPK]) // see [RULE10]
        else $error("refused speaker path started a sequence");
    a_enable_runs_seq: assert property (wr_enables && !reject && new_req[opc_pkg::CH_SPK] && !path_busy[opc_pkg::CH_SPK]
        |-> ##[2:260] path_on[opc_pkg::CH_SPK]) // see [RULE6]
        else $error("speaker enable sequence did not finish in time");
    a_pump_follows_hp: assert property ((path_on[1] || path_on[0]) |-> ##1 charge_pump_en_o) // see [RULE5]
        else $error("charge pump off while headphone active");
    a_hp_done_irq: assert property ((path_done[1] || path_done[0]) |=> irq_status[opc_pkg::IRQ_HP_DONE]) // see [RULE7]
        else $error("headphone sequence end not flagged");
    a_underclk_flag: assert property (underclk_evt |=> irq_status[opc_pkg::IRQ_UNDERCLK] ##1 (gpio_sel != 2'h1 || gpio_o)) // see [RULE12]
        else $error("underclock not reported");
    a_gpio_seq_state: assert property (gpio_sel == opc_pkg::GPIO_SEL_SEQ && hp_busy |=> gpio_o) // see [RULE8]
        else $error("gpio does not show sequence state");
    a_raw_status_read: assert property (reg_rd_i && reg_addr_i == opc_pkg::ADDR_RAW_STATUS
        |=> reg_rdata_o == {14'h0000, $past(path_on[1:0])}) // see [RULE13]
        else $error("raw status readback wrong");
    a_enable_readback: assert property (wr_enables ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == opc_pkg::ADDR_ENABLES)
        |=> reg_rdata_o[7] == $past(reg_wdata_i[7], 3)) // see [RULE2]
        else $error("enable readback wrong");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000) // see [RULE13]
        else $error("read data not zero outside a read");
endmodule

//--- rtl/opc_path_seq.sv
// Purpose: pop-suppressed enable and disable sequence of one path
// Assumes: request is a level from the same clock
// Notes: a request change mid-sequence is served once it ends
`timescale 1ns/10ps
module opc_path_seq (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic request_i,
    output logic enabled_o,
    output logic busy_o,
    output logic done_o
);
    opc_pkg::opc_seq_e state;
    logic [8:0] count;

    // ----------------------------------------
    // sequence state
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= opc_pkg::SEQ_OFF;
            count <= 9'h000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                opc_pkg::SEQ_OFF: begin
                    if (request_i) begin
                        state <= opc_pkg::SEQ_UP;
                        count <= opc_pkg::SEQ_CYCLES;
                    end
                end
                opc_pkg::SEQ_ON: begin
                    if (!request_i) begin
                        state <= opc_pkg::SEQ_DOWN;
                        count <= opc_pkg::SEQ_CYCLES;
                    end
                end
                opc_pkg::SEQ_UP, opc_pkg::SEQ_DOWN: begin
                    if (count == 9'h001) begin
                        state <= (state == opc_pkg::SEQ_UP) ? opc_pkg::SEQ_ON : opc_pkg::SEQ_OFF;
                        done_o <= 1'b1;
                    end
                    count <= count - 9'h001;
                end
                default: state <= opc_pkg::SEQ_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // status follows finished sequence only
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enabled_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state == opc_pkg::SEQ_UP) || (state == opc_pkg::SEQ_DOWN);
            if (done_o) begin
                enabled_o <= (state == opc_pkg::SEQ_ON);
            end
        end
    end
endmodule

//--- rtl/opc_pkg.sv
// Purpose: constants and types for the output path enable control
// Assumes: 125 MHz core clock, plain register port with 16-bit data
// Notes: offsets are register addresses on the port
package opc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [15:0] ADDR_ENABLES = 16'h0400;
    localparam logic [15:0] ADDR_STATUS = 16'h0401;
    localparam logic [15:0] ADDR_RAW_STATUS = 16'h0406;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0410;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h0411;
    localparam logic [15:0] ADDR_CONFIG = 16'h0412;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_SPEAKER_LEFT = 7;
    localparam int BIT_HEADPHONE_LEFT = 1;
    localparam int BIT_HEADPHONE_RIGHT = 0;
    localparam int CH_SPK = 2;
    localparam int CH_HPL = 1;
    localparam int CH_HPR = 0;
    localparam int NUM_CH = 3;
    localparam int IRQ_HP_DONE = 0;
    localparam int IRQ_SPK_DONE = 1;
    localparam int IRQ_UNDERCLK = 2;
    localparam int IRQ_W = 3;
    localparam int CFG_MONO = 0;
    localparam int CFG_GPIO_LSB = 1;
    localparam int CFG_RATE_LSB = 4;
    localparam int RATE_W = 4;
    localparam logic [1:0] GPIO_SEL_SEQ = 2'h0;
    localparam logic [1:0] GPIO_SEL_UNDERCLK = 2'h1;
    localparam logic [1:0] GPIO_SEL_BOTH = 2'h2;
    // ----------------------------------------
    // reset values and clock budget
    // ----------------------------------------
    localparam logic [15:0] RESET_ENABLES = 16'h0000;
    localparam logic [15:0] RESET_CONFIG = 16'h0000;
    localparam logic [IRQ_W-1:0] RESET_IRQ_MASK = 3'h7;
    localparam logic [9:0] HP_PATH_CYCLES = 10'h040;
    localparam logic [9:0] SPK_PATH_CYCLES = 10'h060;
    // ----------------------------------------
    // sequence timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEQ_TIME_NS = 2000;
    localparam int SEQ_CYCLES_INT = (SEQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] SEQ_CYCLES = 9'(SEQ_CYCLES_INT);
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        SEQ_OFF = 4'h1,
        SEQ_UP = 4'h2,
        SEQ_ON = 4'h4,
        SEQ_DOWN = 4'h8
    } opc_seq_e;
    typedef struct packed {
        logic speaker_left;
        logic headphone_left;
        logic headphone_right;
    } opc_paths_s;
endpackage

//--- rtl/opc_sticky_bit.sv
// Purpose: one sticky event flag cleared by writing a one
// Assumes: set and clear are single-cycle pulses
// Notes: a set in the clear cycle wins
`timescale 1ns/10ps
module opc_sticky_bit (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule

//--- tb/opc_output_path_ctrl_tb.sv
// Purpose: self-checking bench for the output path enable control
// Assumes: 125 MHz core clock, reads answered one cycle after the strobe
// Notes: read results go through a queue of expected values
`timescale 1ns/10ps
module opc_output_path_ctrl_tb;
    // ----------------------------------------
    // signals and instance
    // ----------------------------------------
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [9:0] clk_cycles_avail_i = 10'h3ff;
    logic [15:0] reg_rdata_o;
    opc_pkg::opc_paths_s path_drive_o;
    logic charge_pump_en_o;
    logic hp_mono_btl_o;
    logic spk_phase_invert_o;
    logic [3:0] dac_rate_o;
    logic irq_o;
    logic gpio_o;
    logic rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int compares = 0;
    integer seed = 55;
    logic [15:0] rnd;
    opc_output_path_ctrl i_opc_output_path_ctrl (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .clk_cycles_avail_i(clk_cycles_avail_i), .reg_rdata_o(reg_rdata_o),
        .path_drive_o(path_drive_o), .charge_pump_en_o(charge_pump_en_o),
        .hp_mono_btl_o(hp_mono_btl_o), .spk_phase_invert_o(spk_phase_invert_o),
        .dac_rate_o(dac_rate_o), .irq_o(irq_o), .gpio_o(gpio_o)
    );
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // ----------------------------------------
    // compare, report and bus tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        @(posedge clk_sys_i);
        reg_addr_i <= addr;
        reg_wdata_i <= data;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= addr;
        reg_rd_i <= 1'b1;
        exp_q.push_back(exp);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    // ----------------------------------------
    // read data watcher
    // ----------------------------------------
    always @(posedge clk_sys_i) begin
        rd_seen <= reg_rd_i;
    end
    always @(negedge clk_sys_i) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("MISMATCH t=%0t seen=%h exp=none", $time, reg_rdata_o);
            end else begin
                check(reg_rdata_o, exp_q.pop_front());
            end
        end
    end
    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        miscompares++;
        summarize();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // reset values and unmapped read
        rd(opc_pkg::ADDR_ENABLES, 16'h0000);
        rd(opc_pkg::ADDR_STATUS, 16'h0000);
        rd(opc_pkg::ADDR_RAW_STATUS, 16'h0000);
        rd(opc_pkg::ADDR_IRQ_MASK, 16'h0007);
        rd(opc_pkg::ADDR_CONFIG, 16'h0000);
        rd(16'h0405, 16'h0000);
        settle(1);
        check(16'(path_drive_o), 16'h0000);
        check(16'(spk_phase_invert_o), 16'h0001);
        $display("test reset done");
        // headphone enable with junk in unused bits
        rnd = 16'($random(seed));
        wr(opc_pkg::ADDR_ENABLES, (rnd & 16'hff7c) | 16'h0003);
        settle(4);
        check(16'(path_drive_o), 16'h0003);
        check(16'(charge_pump_en_o), 16'h0001);
        wr(16'h0405, rnd);
        rd(opc_pkg::ADDR_ENABLES, 16'h0003);
        rd(opc_pkg::ADDR_RAW_STATUS, 16'h0000);
        settle(250);
        rd(opc_pkg::ADDR_RAW_STATUS, 16'h0003);
        rd(opc_pkg::ADDR_STATUS, 16'h0000);
        rd(opc_pkg::ADDR_IRQ_STATUS, 16'h0001);
        settle(1);
        check(16'(irq_o), 16'h0001);
        $display("test headphone enable done");
        // interrupt mask and clear
        wr(opc_pkg::ADDR_IRQ_MASK, 16'h0000);
        settle(2);
        check(16'(irq_o), 16'h0000);
        wr(opc_pkg::ADDR_IRQ_MASK, 16'h0007);
        settle(2);
        check(16'(irq_o), 16'h0001);
        wr(opc_pkg::ADDR_IRQ_STATUS, 16'h0001);
        rd(opc_pkg::ADDR_IRQ_STATUS, 16'h0000);
        settle(2);
        check(16'(irq_o), 16'h0000);
        $display("test interrupt done");
        // speaker enable refused for lack of clock cycles
        @(posedge clk_sys_i);
        clk_cycles_avail_i <= 10'h09f;
        wr(opc_pkg::ADDR_ENABLES, 16'h0083);
        rd(opc_pkg::ADDR_ENABLES, 16'h0083);
        settle(4);
        check(16'(path_drive_o), 16'h0003);
        rd(opc_pkg::ADDR_IRQ_STATUS, 16'h0004);
        rnd = 16'($random(seed));
        wr(opc_pkg::ADDR_CONFIG, {rnd[15:4], 4'h3});
        rd(opc_pkg::ADDR_CONFIG, {8'h00, rnd[7:4], 4'h3});
        settle(2);
        check(16'(gpio_o), 16'h0001);
        check(16'(hp_mono_btl_o), 16'h0001);
        check(16'(dac_rate_o), 16'(rnd[7:4]));
        settle(260);
        rd(opc_pkg::ADDR_STATUS, 16'h0000);
        rd(opc_pkg::ADDR_RAW_STATUS, 16'h0003);
        settle(1);
        check(16'(path_drive_o), 16'h0003);
        $display("test underclock done");
        // retry with enough cycles, flag on the pin in combined mode
        @(posedge clk_sys_i);
        clk_cycles_avail_i <= 10'h3ff;
        wr(opc_pkg::ADDR_ENABLES, 16'h0083);
        settle(4);
        check(16'(path_drive_o), 16'h0007);
        settle(260);
        rd(opc_pkg::ADDR_STATUS, 16'h0080);
        rd(opc_pkg::ADDR_IRQ_STATUS, 16'h0006);
        wr(opc_pkg::ADDR_CONFIG, 16'h0004);
        settle(2);
        check(16'(gpio_o), 16'h0001);
        wr(opc_pkg::ADDR_IRQ_STATUS, 16'h0007);
        rd(opc_pkg::ADDR_IRQ_STATUS, 16'h0000);
        settle(1);
        check(16'(gpio_o), 16'h0000);
        $display("test speaker enable done");
        // disable all, sequence state on the pin
        wr(opc_pkg::ADDR_CONFIG, 16'h0000);
        settle(2);
        check(16'(gpio_o), 16'h0000);
        check(16'(hp_mono_btl_o), 16'h0000);
        wr(opc_pkg::ADDR_ENABLES, 16'h0000);
        settle(4);
        check(16'(gpio_o), 16'h0001);
        check(16'(path_drive_o), 16'h0007);
        rd(opc_pkg::ADDR_RAW_STATUS, 16'h0003);
        settle(260);
        rd(opc_pkg::ADDR_RAW_STATUS, 16'h0000);
        rd(opc_pkg::ADDR_STATUS, 16'h0000);
        rd(opc_pkg::ADDR_IRQ_STATUS, 16'h0003);
        settle(2);
        check(16'(path_drive_o), 16'h0000);
        check(16'(charge_pump_en_o), 16'h0000);
        check(16'(gpio_o), 16'h0000);
        $display("test disable done");
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) begin
            @(posedge clk_sys_i);
        end
        if (exp_q.size() != 0) begin
            miscompares++;
        end
        summarize();
    end
endmodule
